// >>> design/fri_defs.svh
// constants for the serial flash resume, power-down and id host controller
// ----------------------------------------------------------------------------
// Contract
// [R1] resume accepted only when suspended and idle
// [R2] resume clears suspend, busy within 200ns
// [R3] resume ignored otherwise, state unchanged
// [R4] resume ignored after power loss in suspend
// [R5] host waits suspend spacing after resume
// [R6] power-down needs chip select after eighth bit
// [R7] device enters power-down within entry time
// [R8] power-down accepts only the release opcode
// [R9] device powers up in normal operation
// [R10] host holds chip select high for wake time
// [R11] device id: opcode, three dummy bytes, msb first
// [R12] device id repeats until chip select rises
// [R13] release with id waits wake-with-id time
// [R14] release and id ignored while busy
// [R15] manufacturer id: opcode, zero 24-bit address
// [R16] manufacturer and device id alternate continuously
// [R17] dual id read: two bits per clock
// [R18] quad id read: four bits per clock
// [R19] dual and quad mode byte upper nibble ones
// [R20] unique id: opcode, four dummy bytes, 64 bits
// [R21] suspend accepted only while busy, not suspended
// [R22] suspend sets flag, busy clears within suspend time
// ----------------------------------------------------------------------------
`ifndef FRI_DEFS_SVH
`define FRI_DEFS_SVH
// opcodes
`define FRI_OPC_RESUME 8'h7A
`define FRI_OPC_SUSPEND 8'h75
`define FRI_OPC_PDOWN 8'hB9
`define FRI_OPC_RELEASE 8'hAB
`define FRI_OPC_MFR 8'h90
`define FRI_OPC_MFR2 8'h92
`define FRI_OPC_MFR4 8'h94
`define FRI_OPC_UID 8'h4B
// phase lengths in serial clocks
`define FRI_OPC_CLKS 7'h08
`define FRI_DEVID_DUMMY 7'h18
`define FRI_ADDR1_CLKS 7'h18
`define FRI_ADDR2_CLKS 7'h10
`define FRI_ADDR4_CLKS 7'h08
`define FRI_UID_DUMMY 7'h20
`define FRI_QUAD_DUMMY 7'h04
`define FRI_ID1_CLKS 7'h08
`define FRI_MFR1_CLKS 7'h10
`define FRI_MFR2_CLKS 7'h08
`define FRI_MFR4_CLKS 7'h04
`define FRI_UID_CLKS 7'h40
// address word with continuous read mode byte Fxh
`define FRI_ADDR_MODE 32'h000000F0
// timing, in ns, and derived 200 MHz cycle counts (least times round up)
`define FRI_CLK_MHZ 200
`define FRI_TSUS_NS 20000
`define FRI_TDP_NS 3000
`define FRI_WAKE_TIME_NS 3000
`define FRI_WAKE_WITH_ID_TIME_NS 1800
`define FRI_TCSH_NS 50
`define FRI_CYC(ns) (((ns) * `FRI_CLK_MHZ + 999) / 1000)
`define FRI_TSUS_CYC 12'(`FRI_CYC(`FRI_TSUS_NS))
`define FRI_TDP_CYC 12'(`FRI_CYC(`FRI_TDP_NS))
`define FRI_WAKE_TIME_CYC 12'(`FRI_CYC(`FRI_WAKE_TIME_NS))
`define FRI_WAKE_WITH_ID_TIME_CYC 12'(`FRI_CYC(`FRI_WAKE_WITH_ID_TIME_NS))
`define FRI_TCSH_CYC 12'(`FRI_CYC(`FRI_TCSH_NS))
// pin reset values: io0 and hold/wp driven high, io1 released
`define FRI_IO_IDLE 4'hF
`define FRI_OE_IDLE 4'hD
`endif

// >>> design/fri_pkg.sv
// types of the flash resume, power-down and id host controller
`default_nettype none
package fri_pkg;
  typedef enum logic [3:0] {
    FRI_OP_RESUME, FRI_OP_SUSPEND, FRI_OP_PDOWN, FRI_OP_RELEASE, FRI_OP_DEV_ID,
    FRI_OP_MFR_ID, FRI_OP_MFR_ID2, FRI_OP_MFR_ID4, FRI_OP_UID
  } fri_op_t;
  typedef enum logic [1:0] {FRI_W1, FRI_W2, FRI_W4} fri_wid_t;
  typedef struct packed {
    logic [6:0] nclk;
    fri_wid_t wid;
    logic [31:0] txd;
    logic rx;
    logic last;
  } fri_phase_t;
endpackage : fri_pkg
`default_nettype wire

// >>> design/fri_shift_if.sv
// carrier between the command sequencer and the serial shifter
`timescale 1ns/1ps
`default_nettype none
interface fri_shift_if;
  logic start;
  fri_pkg::fri_phase_t ph;
  logic done;
  logic [63:0] rxd;
  modport ctrl (output start, output ph, input done, input rxd);
  modport shift (input start, input ph, output done, output rxd);
endinterface : fri_shift_if
`default_nettype wire

// >>> design/fri_shifter.sv
// serial clock divider and lane shifter for one phase of a frame
`timescale 1ns/1ps
`default_nettype none
`include "fri_defs.svh"
module fri_shifter #(
  parameter int HALF = 4
) (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // async reset, active low
  fri_shift_if.shift sif, // phase request and result
  output logic sck, // serial clock
  output logic [3:0] io_out, // lane drive values
  output logic [3:0] io_oe, // lane drive enables
  input wire logic [3:0] io_in // lane pin levels
);
  typedef enum {FRI_S_IDLE, FRI_S_LOW, FRI_S_HIGH} fri_sst_t;
  fri_sst_t st_r;
  logic [3:0] s1_r, s2_r;
  logic [7:0] hcnt_r;
  logic [6:0] cnt_r;
  logic [31:0] sh_r;
  logic [63:0] rxd_r;
  fri_pkg::fri_wid_t wid_r;
  logic rx_r;
  logic done_r;

  // ---------------------------------------------------------------------------
  // lane helpers
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] lane_out(fri_pkg::fri_wid_t w, logic [31:0] d);
    unique case (w)
      fri_pkg::FRI_W1: lane_out = {3'h7, d[31]};
      fri_pkg::FRI_W2: lane_out = {2'h3, d[31:30]};
      fri_pkg::FRI_W4: lane_out = d[31:28];
      default: lane_out = `FRI_IO_IDLE;
    endcase
  endfunction : lane_out

  function automatic logic [3:0] lane_oe(fri_pkg::fri_wid_t w, logic rx);
    unique case (w)
      fri_pkg::FRI_W1: lane_oe = `FRI_OE_IDLE;
      fri_pkg::FRI_W2: lane_oe = rx ? 4'hC : 4'hF;
      fri_pkg::FRI_W4: lane_oe = rx ? 4'h0 : 4'hF;
      default: lane_oe = `FRI_OE_IDLE;
    endcase
  endfunction : lane_oe

  function automatic logic [31:0] shift_tx(fri_pkg::fri_wid_t w, logic [31:0] d);
    unique case (w)
      fri_pkg::FRI_W1: shift_tx = {d[30:0], 1'h0};
      fri_pkg::FRI_W2: shift_tx = {d[29:0], 2'h0};
      default: shift_tx = {d[27:0], 4'h0};
    endcase
  endfunction : shift_tx

  function automatic logic [63:0] shift_rx(fri_pkg::fri_wid_t w, logic [63:0] r, logic [3:0] i);
    unique case (w)
      fri_pkg::FRI_W1: shift_rx = {r[62:0], i[1]};
      fri_pkg::FRI_W2: shift_rx = {r[61:0], i[1:0]};
      default: shift_rx = {r[59:0], i[3:0]};
    endcase
  endfunction : shift_rx

  // ---------------------------------------------------------------------------
  // pin synchroniser: the device answers off our clock, so two flops first
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= io_in;
      s2_r <= s1_r;
    end
  end

  // divider and shifter; data changes with sck low, sampled as sck rises,
  // so HALF must cover the two-flop delay plus device output time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= FRI_S_IDLE;
      sck <= 1'b0;
      io_out <= `FRI_IO_IDLE;
      io_oe <= `FRI_OE_IDLE;
      hcnt_r <= 8'h00;
      cnt_r <= 7'h00;
      sh_r <= 32'h0;
      rxd_r <= 64'h0;
      wid_r <= fri_pkg::FRI_W1;
      rx_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        FRI_S_IDLE: if (sif.start) begin
          sh_r <= sif.ph.txd;
          wid_r <= sif.ph.wid;
          rx_r <= sif.ph.rx;
          cnt_r <= sif.ph.nclk;
          hcnt_r <= 8'h00;
          rxd_r <= 64'h0;
          io_out <= lane_out(sif.ph.wid, sif.ph.txd);
          io_oe <= lane_oe(sif.ph.wid, sif.ph.rx);
          st_r <= FRI_S_LOW;
        end
        FRI_S_LOW: if (hcnt_r == 8'(HALF - 1)) begin
          sck <= 1'b1;
          hcnt_r <= 8'h00;
          if (rx_r) rxd_r <= shift_rx(wid_r, rxd_r, s2_r);
          st_r <= FRI_S_HIGH;
        end else begin
          hcnt_r <= hcnt_r + 8'h01;
        end
        FRI_S_HIGH: if (hcnt_r == 8'(HALF - 1)) begin
          sck <= 1'b0;
          hcnt_r <= 8'h00;
          cnt_r <= cnt_r - 7'h01;
          sh_r <= shift_tx(wid_r, sh_r);
          io_out <= lane_out(wid_r, shift_tx(wid_r, sh_r));
          if (cnt_r == 7'h01) begin
            // free the lanes at the last fall: the device may answer right away
            io_oe <= lane_oe(wid_r, 1'b1);
            done_r <= 1'b1;
            st_r <= FRI_S_IDLE;
          end else begin
            st_r <= FRI_S_LOW;
          end
        end else begin
          hcnt_r <= hcnt_r + 8'h01;
        end
      endcase
    end
  end

  assign sif.done = done_r;
  assign sif.rxd = rxd_r;
endmodule : fri_shifter
`default_nettype wire

// >>> design/fri_host.sv
// host controller issuing resume, suspend, power-down and id instructions
`timescale 1ns/1ps
`default_nettype none
`include "fri_defs.svh"
module fri_host #(
  parameter int HALF = 4
) (
  input wire logic core_clk, // system clock, 200 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic cmd_valid, // command request
  input wire fri_pkg::fri_op_t cmd_op, // command code
  output logic cmd_ready, // command may be taken
  output logic rsp_valid, // one-cycle completion pulse
  output logic rsp_refused, // completion was a refusal
  output logic [63:0] rsp_data, // id bits, last bit received at lsb
  output logic powered_down, // device believed in power-down
  output logic cs_n, // chip select, active low
  output logic sck, // serial clock
  output logic [3:0] io_out, // lane drive values
  output logic [3:0] io_oe, // lane drive enables
  input wire logic [3:0] io_in // lane pin levels
);
  typedef enum {FRI_H_IDLE, FRI_H_RUN, FRI_H_HOLD} fri_hst_t;
  fri_hst_t st_r;
  fri_pkg::fri_op_t cur_r;
  logic [1:0] step_r;
  logic [11:0] gap_r;
  logic [11:0] sus_guard_r;
  logic start_r;
  fri_pkg::fri_phase_t ph_r;
  logic take;
  logic refuse;

  fri_shift_if sif ();

  fri_shifter #(.HALF(HALF)) u_shift (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sif(sif.shift),
    .sck(sck),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_in(io_in)
  );

  assign sif.start = start_r;
  assign sif.ph = ph_r;

  // ---------------------------------------------------------------------------
  // frame recipes: one phase per step
  // ---------------------------------------------------------------------------
  function automatic fri_pkg::fri_phase_t mk(logic [6:0] n, fri_pkg::fri_wid_t w,
                                             logic [31:0] d, logic rx, logic last);
    mk = '{nclk: n, wid: w, txd: d, rx: rx, last: last};
  endfunction : mk

  function automatic logic [7:0] opc(fri_pkg::fri_op_t op);
    unique case (op)
      fri_pkg::FRI_OP_RESUME: opc = `FRI_OPC_RESUME;
      fri_pkg::FRI_OP_SUSPEND: opc = `FRI_OPC_SUSPEND;
      fri_pkg::FRI_OP_PDOWN: opc = `FRI_OPC_PDOWN;
      fri_pkg::FRI_OP_MFR_ID: opc = `FRI_OPC_MFR;
      fri_pkg::FRI_OP_MFR_ID2: opc = `FRI_OPC_MFR2;
      fri_pkg::FRI_OP_MFR_ID4: opc = `FRI_OPC_MFR4;
      fri_pkg::FRI_OP_UID: opc = `FRI_OPC_UID;
      default: opc = `FRI_OPC_RELEASE;
    endcase
  endfunction : opc

  function automatic fri_pkg::fri_phase_t recipe(fri_pkg::fri_op_t op, logic [1:0] s);
    logic lone;
    lone = (op == fri_pkg::FRI_OP_RESUME) || (op == fri_pkg::FRI_OP_SUSPEND) ||
           (op == fri_pkg::FRI_OP_PDOWN) || (op == fri_pkg::FRI_OP_RELEASE);
    recipe = mk(`FRI_OPC_CLKS, fri_pkg::FRI_W1, {opc(op), 24'h0}, 1'b0, lone); // [R6]
    if (s != 2'h0) begin
      unique case (op)
        fri_pkg::FRI_OP_DEV_ID: recipe = (s == 2'h1) ? // [R11]
          mk(`FRI_DEVID_DUMMY, fri_pkg::FRI_W1, 32'h0, 1'b0, 1'b0) :
          mk(`FRI_ID1_CLKS, fri_pkg::FRI_W1, 32'h0, 1'b1, 1'b1);
        fri_pkg::FRI_OP_MFR_ID: recipe = (s == 2'h1) ? // [R15]
          mk(`FRI_ADDR1_CLKS, fri_pkg::FRI_W1, 32'h0, 1'b0, 1'b0) :
          mk(`FRI_MFR1_CLKS, fri_pkg::FRI_W1, 32'h0, 1'b1, 1'b1);
        fri_pkg::FRI_OP_MFR_ID2: recipe = (s == 2'h1) ? // [R17] [R19]
          mk(`FRI_ADDR2_CLKS, fri_pkg::FRI_W2, `FRI_ADDR_MODE, 1'b0, 1'b0) :
          mk(`FRI_MFR2_CLKS, fri_pkg::FRI_W2, 32'h0, 1'b1, 1'b1);
        fri_pkg::FRI_OP_MFR_ID4: recipe = (s == 2'h1) ? // [R18] [R19]
          mk(`FRI_ADDR4_CLKS, fri_pkg::FRI_W4, `FRI_ADDR_MODE, 1'b0, 1'b0) :
          (s == 2'h2) ? mk(`FRI_QUAD_DUMMY, fri_pkg::FRI_W4, 32'h0, 1'b1, 1'b0) :
          mk(`FRI_MFR4_CLKS, fri_pkg::FRI_W4, 32'h0, 1'b1, 1'b1);
        default: recipe = (s == 2'h1) ? // [R20]
          mk(`FRI_UID_DUMMY, fri_pkg::FRI_W1, 32'h0, 1'b0, 1'b0) :
          mk(`FRI_UID_CLKS, fri_pkg::FRI_W1, 32'h0, 1'b1, 1'b1);
      endcase
    end
  endfunction : recipe

  // chip-select-high time after each frame
  function automatic logic [11:0] gap_for(fri_pkg::fri_op_t op, logic pd);
    unique case (op)
      fri_pkg::FRI_OP_PDOWN: gap_for = `FRI_TDP_CYC; // [R7]
      fri_pkg::FRI_OP_RELEASE: gap_for = `FRI_WAKE_TIME_CYC; // [R10]
      fri_pkg::FRI_OP_DEV_ID: gap_for = pd ? `FRI_WAKE_WITH_ID_TIME_CYC : `FRI_TCSH_CYC; // [R13]
      default: gap_for = `FRI_TCSH_CYC;
    endcase
  endfunction : gap_for

  // ---------------------------------------------------------------------------
  // command acceptance
  // ---------------------------------------------------------------------------
  // power-down takes only release and device id; suspend inside the resume spacing is refused
  assign take = cmd_valid && cmd_ready;
  assign refuse = (powered_down && (cmd_op != fri_pkg::FRI_OP_RELEASE) && // [R8]
                   (cmd_op != fri_pkg::FRI_OP_DEV_ID)) ||
                  ((cmd_op == fri_pkg::FRI_OP_SUSPEND) && (sus_guard_r != 12'h0)); // [R5]

  // sequencer: chip select, phase launch, gap after frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= FRI_H_HOLD;
      cur_r <= fri_pkg::FRI_OP_SUSPEND;
      step_r <= 2'h0;
      gap_r <= 12'h0;
      start_r <= 1'b0;
      ph_r <= '0;
      cs_n <= 1'b1;
      cmd_ready <= 1'b0;
    end else begin
      start_r <= 1'b0;
      unique case (st_r)
        FRI_H_IDLE: if (take && !refuse) begin
          cur_r <= cmd_op;
          step_r <= 2'h0;
          ph_r <= recipe(cmd_op, 2'h0);
          start_r <= 1'b1;
          cs_n <= 1'b0;
          cmd_ready <= 1'b0;
          st_r <= FRI_H_RUN;
        end
        FRI_H_RUN: if (sif.done) begin
          if (ph_r.last) begin
            cs_n <= 1'b1; // [R6] rises right after the final bit
            gap_r <= gap_for(cur_r, powered_down);
            st_r <= FRI_H_HOLD;
          end else begin
            step_r <= step_r + 2'h1;
            ph_r <= recipe(cur_r, step_r + 2'h1);
            start_r <= 1'b1;
          end
        end
        FRI_H_HOLD: if (gap_r == 12'h0) begin
          cmd_ready <= 1'b1;
          st_r <= FRI_H_IDLE;
        end else begin
          gap_r <= gap_r - 12'h1; // [R10] [R13] chip select kept high
        end
      endcase
    end
  end

  // power-down belief: set after entry time, cleared after wake time, or wake-with-id time for device id
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powered_down <= 1'b0;
    end else if (st_r == FRI_H_HOLD && gap_r == 12'h0) begin
      if (cur_r == fri_pkg::FRI_OP_PDOWN) powered_down <= 1'b1; // [R7]
      else if (cur_r == fri_pkg::FRI_OP_RELEASE || cur_r == fri_pkg::FRI_OP_DEV_ID)
        powered_down <= 1'b0;
    end
  end

  // suspend spacing after a resume frame ends
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sus_guard_r <= 12'h0;
    end else if (st_r == FRI_H_RUN && sif.done && ph_r.last &&
                 cur_r == fri_pkg::FRI_OP_RESUME) begin
      sus_guard_r <= `FRI_TSUS_CYC; // [R5]
    end else if (sus_guard_r != 12'h0) begin
      sus_guard_r <= sus_guard_r - 12'h1;
    end
  end

  // completion and refusal report
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_refused <= 1'b0;
      rsp_data <= 64'h0;
    end else begin
      rsp_valid <= 1'b0;
      if (st_r == FRI_H_IDLE && take && refuse) begin
        rsp_valid <= 1'b1;
        rsp_refused <= 1'b1;
      end else if (st_r == FRI_H_RUN && sif.done && ph_r.last) begin
        rsp_valid <= 1'b1;
        rsp_refused <= 1'b0;
        rsp_data <= ph_r.rx ? sif.rxd : 64'h0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic done_last;
  assign done_last = st_r == FRI_H_RUN && sif.done && ph_r.last;

  sus_spacing_a: assert property ($fell(cs_n) && cur_r == fri_pkg::FRI_OP_SUSPEND // [R5]
    |-> $past(sus_guard_r) == 12'h0) else $error("suspend sent inside spacing");
  pd_cs_rise_a: assert property (done_last && cur_r == fri_pkg::FRI_OP_PDOWN // [R6]
    |=> $rose(cs_n) && $past(ph_r.nclk) == `FRI_OPC_CLKS) else $error("pd cs not at bit 8");
  wake_len_a: assert property ($rose(cs_n) && cur_r == fri_pkg::FRI_OP_RELEASE // [R10]
    |-> gap_r == `FRI_WAKE_TIME_CYC ##1 (cs_n && !cmd_ready) [*8]) else $error("wake time short");
  id_wake_a: assert property ($rose(cs_n) && cur_r == fri_pkg::FRI_OP_DEV_ID // [R13]
    && powered_down |-> gap_r == `FRI_WAKE_WITH_ID_TIME_CYC) else $error("wake with id short");
  dev_id_dummy_a: assert property (start_r && cur_r == fri_pkg::FRI_OP_DEV_ID // [R11]
    && step_r == 2'h1 |-> ph_r.nclk == 7'h18 && ph_r.txd == 32'h0) else $error("id dummy");
  mfr_addr_a: assert property (start_r && cur_r == fri_pkg::FRI_OP_MFR_ID // [R15]
    && step_r == 2'h1 |-> ph_r.nclk == 7'h18 && ph_r.txd == 32'h0) else $error("mfr addr");
  dual_lanes_a: assert property (start_r && cur_r == fri_pkg::FRI_OP_MFR_ID2 // [R17]
    && step_r != 2'h0 |-> ph_r.wid == fri_pkg::FRI_W2) else $error("dual width");
  quad_lanes_a: assert property (start_r && cur_r == fri_pkg::FRI_OP_MFR_ID4 // [R18]
    && step_r != 2'h0 |-> ph_r.wid == fri_pkg::FRI_W4) else $error("quad width");
  mode_byte_a: assert property (start_r && step_r == 2'h1 && // [R19]
    (cur_r == fri_pkg::FRI_OP_MFR_ID2 || cur_r == fri_pkg::FRI_OP_MFR_ID4)
    |-> ph_r.txd[7:4] == 4'hF) else $error("mode byte nibble");
  uid_len_a: assert property (start_r && cur_r == fri_pkg::FRI_OP_UID && step_r == 2'h2 // [R20]
    |-> ph_r.nclk == 7'h40 && ph_r.rx) else $error("uid length");
  pd_refuse_a: assert property (take && powered_down && // [R8]
    cmd_op != fri_pkg::FRI_OP_RELEASE && cmd_op != fri_pkg::FRI_OP_DEV_ID
    |=> rsp_valid && rsp_refused && cs_n) else $error("pd op");

  pd_cycle_c: cover property (powered_down ##[1:1000] !powered_down);
  resume_c: cover property (done_last && cur_r == fri_pkg::FRI_OP_RESUME);
  quad_id_c: cover property (done_last && cur_r == fri_pkg::FRI_OP_MFR_ID4);
  uid_c: cover property (done_last && cur_r == fri_pkg::FRI_OP_UID);
endmodule : fri_host
`default_nettype wire

// >>> verif/fri_dev_model.sv
// behavioural serial flash device facing the host controller pins
`timescale 1ns/1ps
`default_nettype none
module fri_dev_model #(
  parameter logic [7:0] MFR = 8'h5C, // arbitrary manufacturer code
  parameter logic [7:0] DEV = 8'h13, // arbitrary device code
  parameter logic [63:0] UID = 64'h0123456789ABCDEF // arbitrary unique number
) (
  input wire logic cs_n, // chip select, active low
  input wire logic sck, // serial clock from the host
  input wire logic [3:0] pin, // resolved lane levels
  output logic [3:0] d_out, // lane values
  output logic [3:0] d_oe, // lane enables
  output logic [7:0] op, // opcode of the current frame
  output logic [31:0] addr, // address and mode bits seen
  output logic pd, // power-down state
  output logic susp, // suspend flag
  output logic busy // busy flag
);
  logic [63:0] sr;
  logic [6:0] nclk;
  logic [2:0] w;
  logic [6:0] t0;
  logic [6:0] cap;
  logic ign;
  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  // lane width and first output clock per opcode; unknown opcodes never answer
  assign w = (op == 8'h92) ? 3'h2 : (op == 8'h94) ? 3'h4 : 3'h1;
  assign t0 = (op == 8'h92) ? 7'h18 : (op == 8'h94) ? 7'h14 : (op == 8'h4B) ? 7'h28 :
              (op == 8'h90 || op == 8'hAB) ? 7'h20 : 7'h7F;
  // quad dummy clocks leave lanes floating, so they stay out of the capture
  assign cap = (op == 8'h94) ? 7'h10 : t0;
  assign ign = (pd && op != 8'hAB) || (busy && op == 8'hAB);
  // power-up: normal mode, erase in flight, no suspend survives power loss
  initial begin
    pd = 1'b0;
    susp = 1'b0;
    busy = 1'b1;
    d_oe = 4'h0;
    d_out = 4'h0;
    op = 8'h00;
    addr = 32'h0;
  end
  // a new frame forgets the previous one
  always @(negedge cs_n) begin
    nclk = 7'h00;
    op = 8'h00;
    addr = 32'h0;
  end
  // inputs are taken on rising edges
  always @(posedge sck) begin
    if (!cs_n && nclk < 7'h08) op = {op[6:0], pin[0]};
    else if (!cs_n && nclk < cap)
      addr = (w == 3'h4) ? {addr[27:0], pin} :
             (w == 3'h2) ? {addr[29:0], pin[1:0]} : {addr[30:0], pin[0]};
    if (!cs_n) nclk = nclk + 7'h01;
    if (!cs_n && nclk == 7'h08)
      sr = (op == 8'h4B) ? UID : (op == 8'hAB) ? {8{DEV}} : {4{MFR, DEV}};
  end
  // id bits leave on falling edges msb first and rotate while clocks run
  always @(negedge sck) begin
    if (!cs_n && !ign && nclk >= t0) begin
      d_oe = (w == 3'h4) ? 4'hF : (w == 3'h2) ? 4'h3 : 4'h2;
      d_out = (w == 3'h4) ? sr[63:60] : (w == 3'h2) ? {2'b00, sr[63:62]} : {2'b00, sr[63], 1'b0};
      sr = (w == 3'h4) ? {sr[59:0], sr[63:60]} :
           (w == 3'h2) ? {sr[61:0], sr[63:62]} : {sr[62:0], sr[63]};
    end
  end
  // ---------------------------------------------------------------
  // state changes at the end of a frame
  // ---------------------------------------------------------------
  // power-down, resume and suspend act only when exactly eight clocks were given; release acts on eight or more
  always @(posedge cs_n) begin
    d_oe = 4'h0;
    if (nclk == 7'h08 && op == 8'hB9 && !pd) pd = 1'b1;
    if (nclk >= 7'h08 && op == 8'hAB && !busy) pd = 1'b0;
    if (nclk == 7'h08 && op == 8'h7A && !pd && susp && !busy) begin
      susp = 1'b0;
      busy = 1'b1;
    end
    if (nclk == 7'h08 && op == 8'h75 && !pd && !susp && busy) begin
      susp = 1'b1;
      busy = 1'b0;
    end
  end
endmodule : fri_dev_model
`default_nettype wire

// >>> verif/fri_host_bench.sv
// self-checking bench for the flash resume, power-down and id host controller
`timescale 1ns/1ps
`default_nettype none
module fri_host_bench;
  localparam logic [7:0] MFR = 8'h5C; // arbitrary manufacturer code
  localparam logic [7:0] DEV = 8'h13; // arbitrary device code
  localparam logic [63:0] UID = 64'h0123456789ABCDEF; // arbitrary unique number
  localparam logic [63:0] ALL = {64{1'b1}};
  localparam fri_pkg::fri_op_t ROP [5] = '{fri_pkg::FRI_OP_DEV_ID, fri_pkg::FRI_OP_MFR_ID,
    fri_pkg::FRI_OP_MFR_ID2, fri_pkg::FRI_OP_MFR_ID4, fri_pkg::FRI_OP_UID};
  localparam logic [7:0] OPC [5] = '{8'hAB, 8'h90, 8'h92, 8'h94, 8'h4B};
  logic core_clk;
  logic rst_n;
  logic cmd_valid;
  fri_pkg::fri_op_t cmd_op;
  logic cmd_ready, rsp_valid, rsp_refused, powered_down, cs_n, sck, pd, susp, busy;
  logic [63:0] rsp_data;
  logic [3:0] io_out, io_oe, io_in, d_out, d_oe;
  logic [7:0] op;
  logic [31:0] addr;
  logic [31:0] seed;
  logic [128:0] exp_q[$];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // a released lane shows the inverse of its last value, never a stale copy
  assign io_in = (io_oe & io_out) | (~io_oe & d_oe & d_out) | (~io_oe & ~d_oe & ~d_out);
  fri_host fri_host_inst (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
    .rsp_data(rsp_data), .powered_down(powered_down), .cs_n(cs_n), .sck(sck),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
  fri_dev_model #(.MFR(MFR), .DEV(DEV), .UID(UID)) fri_dev_model_inst (.cs_n(cs_n),
    .sck(sck), .pin(io_in), .d_out(d_out), .d_oe(d_oe), .op(op), .addr(addr), .pd(pd),
    .susp(susp), .busy(busy));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk_rsp(input logic [128:0] e);
    n_checks++;
    if (rsp_refused !== e[128] || (rsp_data & e[63:0]) !== e[127:64]) begin
      fail_count++;
      $display("Error at %0t: response %b %h", $time, rsp_refused, rsp_data);
    end
  endtask : chk_rsp
  task automatic chk_dev(input logic [43:0] e);
    n_checks++;
    if ({op, addr, pd, powered_down, susp, busy} !== e) begin
      fail_count++;
      $display("Error at %0t: device state %h %h %b", $time, op, addr, {pd, powered_down});
    end
  endtask : chk_dev
  // one request, held until taken, then wait for its answer and the gap
  task automatic do_cmd(input fri_pkg::fri_op_t o, input logic r, input logic [63:0] d,
                        input logic [63:0] m);
    int k;
    exp_q.push_back({r, d & m, m});
    repeat (rnd() % 4 + 1) @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 9000);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    k = 0;
    while ((exp_q.size() != 0 || cmd_ready !== 1'b1) && k < 9000) begin
      @(negedge core_clk);
      k++;
    end
    // a command that never completes is a failure, not a silent skip
    if (exp_q.size() != 0 || cmd_ready !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: command hung", $time);
      conclude();
    end
  endtask : do_cmd
  // ---------------------------------------------------------------
  // clock, watchdog and response monitor
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // the whole run needs about 10000 cycles; three times that means a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      $display("Error at %0t: run timed out", $time);
      conclude();
    end
  end
  // every completion pulse takes the oldest expectation
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1 && exp_q.size() == 0) begin
      fail_count++;
      $display("Error at %0t: unexpected response", $time);
    end else if (rsp_valid === 1'b1) chk_rsp(exp_q.pop_front());
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = fri_pkg::FRI_OP_RESUME;
    seed = 32'h4;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk_dev({8'h00, 32'h0, 4'h1});
    do_cmd(fri_pkg::FRI_OP_SUSPEND, 1'b0, 64'h0, ALL);
    chk_dev({8'h75, 32'h0, 4'h2});
    $display("test suspend done");
    for (int i = 0; i < 5; i++) begin
      do_cmd(ROP[i], 1'b0, (i == 4) ? UID : {48'h0, MFR, DEV},
             (i == 4) ? ALL : (i == 0) ? 64'hFF : 64'hFFFF);
      chk_dev({OPC[i], (i == 2 || i == 3) ? 32'hF0 : 32'h0, 4'h2});
    end
    $display("test id reads done");
    do_cmd(fri_pkg::FRI_OP_RESUME, 1'b0, 64'h0, ALL);
    chk_dev({8'h7A, 32'h0, 4'h1});
    do_cmd(fri_pkg::FRI_OP_SUSPEND, 1'b1, 64'h0, 64'h0);
    do_cmd(fri_pkg::FRI_OP_RESUME, 1'b0, 64'h0, ALL);
    chk_dev({8'h7A, 32'h0, 4'h1});
    do_cmd(fri_pkg::FRI_OP_DEV_ID, 1'b0, 64'h0, 64'h0);
    chk_dev({8'hAB, 32'h0, 4'h1});
    repeat (4000) @(posedge core_clk);
    do_cmd(fri_pkg::FRI_OP_SUSPEND, 1'b0, 64'h0, ALL);
    chk_dev({8'h75, 32'h0, 4'h2});
    $display("test resume done");
    do_cmd(fri_pkg::FRI_OP_PDOWN, 1'b0, 64'h0, ALL);
    chk_dev({8'hB9, 32'h0, 4'hE});
    do_cmd(fri_pkg::fri_op_t'(rnd() % 4 + 5), 1'b1, 64'h0, 64'h0);
    do_cmd(fri_pkg::FRI_OP_RELEASE, 1'b0, 64'h0, ALL);
    chk_dev({8'hAB, 32'h0, 4'h2});
    do_cmd(fri_pkg::FRI_OP_PDOWN, 1'b0, 64'h0, ALL);
    do_cmd(fri_pkg::FRI_OP_DEV_ID, 1'b0, {56'h0, DEV}, 64'hFF);
    chk_dev({8'hAB, 32'h0, 4'h2});
    $display("test power-down done");
    conclude();
  end
endmodule : fri_host_bench
`default_nettype wire
